// file: shared/ccil_pkg.sv
package ccil_pkg;

  // ==========================================================
  // Register addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h2b;
  localparam logic [7:0] ADDR_INT_FLAG = 8'h2c;
  localparam logic [7:0] ADDR_ERR_COND = 8'h2d;

  // ==========================================================
  // Flag and enable bit positions.
  localparam int BIT_RX0 = 0;
  localparam int BIT_RX1 = 1;
  localparam int BIT_TX0 = 2;
  localparam int BIT_TX1 = 3;
  localparam int BIT_TX2 = 4;
  localparam int BIT_ERR = 5;
  localparam int BIT_WAKE = 6;
  localparam int BIT_MSG_FAULT = 7;

  // Error condition register bit positions.
  localparam int EC_ANY_WARN = 0;
  localparam int EC_RX_WARN = 1;
  localparam int EC_TX_WARN = 2;
  localparam int EC_RX_PASSIVE = 3;
  localparam int EC_TX_PASSIVE = 4;
  localparam int EC_BUS_OFF = 5;
  localparam int EC_RX0_OVF = 6;
  localparam int EC_RX1_OVF = 7;

  // Status register field position.
  localparam int STATUS_CODE_LSB = 1;
  localparam int STATUS_MODE_LSB = 5;

  // ==========================================================
  // Reset values.
  localparam logic [7:0] RESET_INT_ENABLE = 8'h00;
  localparam logic [7:0] RESET_INT_FLAG = 8'h00;
  localparam logic [1:0] RESET_OVF = 2'h0;

  // ==========================================================
  // Pending source codes.
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_ERR = 3'h1;
  localparam logic [2:0] CODE_WAKE = 3'h2;
  localparam logic [2:0] CODE_TX0 = 3'h3;
  localparam logic [2:0] CODE_TX1 = 3'h4;
  localparam logic [2:0] CODE_TX2 = 3'h5;
  localparam logic [2:0] CODE_RX0 = 3'h6;
  localparam logic [2:0] CODE_RX1 = 3'h7;

  // ==========================================================
  // Error count limits.
  localparam int WARN_LIMIT = 96;
  localparam int PASSIVE_LIMIT = 127;
  localparam int BUS_OFF_LIMIT = 255;

  // ==========================================================
  // Operating mode requests and reported mode codes.
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_LISTEN = 2'h2;
  localparam logic [2:0] MODE_CODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_CODE_LISTEN = 3'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_LISTEN = 3'b100
  } ccil_mode_t;

endpackage

// file: rtl/ccil_err_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ccil_err_monitor
  import ccil_pkg::*;
#(
  parameter int TX_CNT_W = 9,
  parameter int RX_CNT_W = 8
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Error counts.
  input wire logic [TX_CNT_W-1:0] tx_error_count_i,
  input wire logic [RX_CNT_W-1:0] rx_error_count_i,
  // Error state bits and change pulse.
  output logic [5:0] err_state_o,
  output logic err_change_o
);

  initial begin
    if (TX_CNT_W < 9 || RX_CNT_W < 8) begin
      $error("Counts too narrow to reach the bus-off or passive limits.");
    end
  end

  logic [5:0] next_err_state;
  logic next_err_change;

  always_comb begin
    next_err_state = '0;
    next_err_state[EC_RX_WARN] = (int'(rx_error_count_i) >= WARN_LIMIT);
    next_err_state[EC_TX_WARN] = (int'(tx_error_count_i) >= WARN_LIMIT);
    next_err_state[EC_ANY_WARN] = next_err_state[EC_RX_WARN] | next_err_state[EC_TX_WARN];
    next_err_state[EC_RX_PASSIVE] = (int'(rx_error_count_i) > PASSIVE_LIMIT);
    next_err_state[EC_TX_PASSIVE] = (int'(tx_error_count_i) > PASSIVE_LIMIT);
    next_err_state[EC_BUS_OFF] = (int'(tx_error_count_i) > BUS_OFF_LIMIT);
    // The summary warning bit is left out of change detection; it only follows the other two.
    next_err_change = (next_err_state[5:1] != err_state_o[5:1]);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_state_o <= 6'h00;
      err_change_o <= 1'b0;
    end else begin
      err_state_o <= next_err_state;
      err_change_o <= next_err_change;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ccil_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
module ccil_prio_enc
  import ccil_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Enabled pending sources.
  input wire logic [7:0] pending_i,
  // Highest priority code.
  output logic [2:0] code_o
);

  // ==========================================================
  // Encoder.
  function automatic logic [2:0] pick_code(input logic [7:0] pend);
    logic [2:0] c;
    c = CODE_NONE;
    if (pend[BIT_RX1]) c = CODE_RX1;
    if (pend[BIT_RX0]) c = CODE_RX0;
    if (pend[BIT_TX2]) c = CODE_TX2;
    if (pend[BIT_TX1]) c = CODE_TX1;
    if (pend[BIT_TX0]) c = CODE_TX0;
    if (pend[BIT_WAKE]) c = CODE_WAKE;
    if (pend[BIT_ERR]) c = CODE_ERR;
    return c;
  endfunction

  logic [2:0] next_code;

  always_comb begin
    next_code = pick_code(pending_i);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_o <= CODE_NONE;
    end else begin
      code_o <= next_code;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ccil_int_logic.sv
`timescale 1ns/1ps
`default_nettype none
module ccil_int_logic
  import ccil_pkg::*;
#(
  parameter int NUM_SRC = 8,
  parameter int TX_CNT_W = 9,
  parameter int RX_CNT_W = 8
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register access from the command decoder.
  input wire logic reg_wr_i,
  input wire logic reg_mod_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_mask_i,
  output logic [7:0] reg_rdata_o,
  // Protocol engine events, one-cycle pulses.
  input wire logic [2:0] tx_empty_i,
  input wire logic [1:0] rx_loaded_i,
  input wire logic msg_fault_i,
  input wire logic bus_activity_i,
  input wire logic [1:0] rx_overflow_i,
  // Error counts.
  input wire logic [TX_CNT_W-1:0] tx_error_count_i,
  input wire logic [RX_CNT_W-1:0] rx_error_count_i,
  // Operating mode request.
  input wire logic mode_req_valid_i,
  input wire logic [1:0] mode_req_i,
  // Outputs.
  output logic int_n_o,
  output logic [2:0] pending_source_code_o,
  output logic [2:0] op_mode_o
);

  initial begin
    if (NUM_SRC != 8) begin
      $error("The source layout is fixed at eight sources.");
    end
  end

  // ==========================================================
  // Helpers.
  function automatic logic [7:0] merge_bits(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [2:0] mode_code(input ccil_mode_t m);
    logic [2:0] c;
    case (m)
      MODE_SLEEP: c = MODE_CODE_SLEEP;
      MODE_LISTEN: c = MODE_CODE_LISTEN;
      default: c = MODE_CODE_NORMAL;
    endcase
    return c;
  endfunction

  // ==========================================================
  // Host access decode.
  logic host_touch;
  logic [7:0] host_mask;
  logic wr_enable;
  logic wr_flag;
  logic wr_err_cond;

  always_comb begin
    host_touch = reg_wr_i | reg_mod_i;
    // A plain write is a masked update with every bit selected.
    host_mask = reg_mod_i ? reg_mask_i : 8'hff;
    wr_enable = host_touch && (reg_addr_i == ADDR_INT_ENABLE);
    wr_flag = host_touch && (reg_addr_i == ADDR_INT_FLAG);
    wr_err_cond = host_touch && (reg_addr_i == ADDR_ERR_COND);
  end

  // ==========================================================
  // Error state monitor and encoder.
  logic [5:0] err_state;
  logic err_change;
  logic [2:0] enc_code;

  ccil_err_monitor #(
    .TX_CNT_W(TX_CNT_W),
    .RX_CNT_W(RX_CNT_W)
  ) u_err_monitor (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tx_error_count_i(tx_error_count_i),
    .rx_error_count_i(rx_error_count_i),
    .err_state_o(err_state),
    .err_change_o(err_change)
  );

  // ==========================================================
  // Operating mode.
  ccil_mode_t mode;
  ccil_mode_t next_mode;
  logic wake_event;

  always_comb begin
    next_mode = mode;
    wake_event = 1'b0;
    case (mode)
      MODE_SLEEP: begin
        if (bus_activity_i) begin
          wake_event = 1'b1;
          next_mode = MODE_LISTEN;
        end else if (mode_req_valid_i && mode_req_i == REQ_NORMAL) begin
          next_mode = MODE_NORMAL;
        end else if (mode_req_valid_i && mode_req_i == REQ_LISTEN) begin
          next_mode = MODE_LISTEN;
        end
      end
      MODE_NORMAL, MODE_LISTEN: begin
        if (mode_req_valid_i) begin
          case (mode_req_i)
            REQ_SLEEP: next_mode = MODE_SLEEP;
            REQ_LISTEN: next_mode = MODE_LISTEN;
            default: next_mode = MODE_NORMAL;
          endcase
        end
      end
      default: next_mode = MODE_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= MODE_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================
  // Receive overflow bits.
  logic [1:0] ovf;
  logic [1:0] next_ovf;
  logic [7:0] ec_merged;

  always_comb begin
    ec_merged = merge_bits({ovf[1], ovf[0], err_state}, reg_wdata_i, host_mask);
    next_ovf = ovf;
    if (wr_err_cond) begin
      next_ovf = {ec_merged[EC_RX1_OVF], ec_merged[EC_RX0_OVF]};
    end
    // A new overflow in the same cycle as a host clear still lands.
    next_ovf = next_ovf | rx_overflow_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf <= RESET_OVF;
    end else begin
      ovf <= next_ovf;
    end
  end

  // ==========================================================
  // Enable register.
  logic [7:0] int_enable;
  logic [7:0] next_int_enable;

  always_comb begin
    next_int_enable = int_enable;
    if (wr_enable) begin
      next_int_enable = merge_bits(int_enable, reg_wdata_i, host_mask);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_enable <= RESET_INT_ENABLE;
    end else begin
      int_enable <= next_int_enable;
    end
  end

  // ==========================================================
  // Flag register.
  logic [7:0] int_flag;
  logic [7:0] next_int_flag;
  logic [7:0] hw_set;
  logic [7:0] hold;

  always_comb begin
    hw_set = 8'h00;
    hw_set[BIT_TX0] = tx_empty_i[0];
    hw_set[BIT_TX1] = tx_empty_i[1];
    hw_set[BIT_TX2] = tx_empty_i[2];
    hw_set[BIT_RX0] = rx_loaded_i[0];
    hw_set[BIT_RX1] = rx_loaded_i[1];
    hw_set[BIT_MSG_FAULT] = msg_fault_i;
    hw_set[BIT_WAKE] = wake_event;
    hw_set[BIT_ERR] = err_change | (|rx_overflow_i);
    // Events in this cycle, and standing overflow bits for the error flag, keep their flag against a host clear.
    hold = hw_set;
    hold[BIT_ERR] = hw_set[BIT_ERR] | (|ovf);
    next_int_flag = int_flag;
    if (wr_flag) begin
      // Host writes may also set flags and so raise an interrupt.
      next_int_flag = merge_bits(int_flag, reg_wdata_i, host_mask) | (int_flag & hold);
    end
    // A hardware set always wins over a host clear in the same cycle.
    next_int_flag = next_int_flag | hw_set;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_flag <= RESET_INT_FLAG;
    end else begin
      int_flag <= next_int_flag;
    end
  end

  // ==========================================================
  // Interrupt pin and pending source code.
  logic [7:0] next_pending;
  logic next_int_n;

  always_comb begin
    // Built from next values so the pin and the encoder code move in the same cycle as the flags; pending_source_code_o follows one cycle later.
    next_pending = next_int_flag & next_int_enable;
    next_int_n = ~(|next_pending);
  end

  ccil_prio_enc u_prio_enc (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pending_i(next_pending),
    .code_o(enc_code)
  );

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= next_int_n;
    end
  end

  // ==========================================================
  // Register read.
  logic [7:0] next_rdata;
  logic [7:0] status_val;

  always_comb begin
    status_val = 8'h00;
    status_val[STATUS_CODE_LSB +: 3] = enc_code;
    status_val[STATUS_MODE_LSB +: 3] = mode_code(mode);
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_STATUS: next_rdata = status_val;
        ADDR_INT_ENABLE: next_rdata = int_enable;
        ADDR_INT_FLAG: next_rdata = int_flag;
        ADDR_ERR_COND: next_rdata = {ovf[1], ovf[0], err_state};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      pending_source_code_o <= CODE_NONE;
      op_mode_o <= MODE_CODE_NORMAL;
    end else begin
      reg_rdata_o <= next_rdata;
      pending_source_code_o <= enc_code;
      op_mode_o <= mode_code(mode);
    end
  end

endmodule
`default_nettype wire

// file: verification/ccil_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ccil_checker
  import ccil_pkg::*;
#(
  parameter int TX_CNT_W = 9
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register writes.
  input wire logic reg_wr_i,
  input wire logic reg_mod_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_mask_i,
  // Events and counts.
  input wire logic [2:0] tx_empty_i,
  input wire logic msg_fault_i,
  input wire logic bus_activity_i,
  input wire logic [1:0] rx_overflow_i,
  input wire logic [TX_CNT_W-1:0] tx_error_count_i,
  // Outputs.
  input wire logic int_n_o,
  input wire logic [2:0] pending_source_code_o,
  input wire logic [2:0] op_mode_o
);
  // ====================
  // Enable shadow. A masked update wins over a plain write, as in the device.
  logic [7:0] en_shadow;
  logic [7:0] next_en_shadow;
  always_comb begin
    next_en_shadow = en_shadow;
    if (reg_mod_i && reg_addr_i == ADDR_INT_ENABLE) begin
      next_en_shadow = (en_shadow & ~reg_mask_i) | (reg_wdata_i & reg_mask_i);
    end else if (reg_wr_i && reg_addr_i == ADDR_INT_ENABLE) begin
      next_en_shadow = reg_wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_shadow <= RESET_INT_ENABLE;
    end else begin
      en_shadow <= next_en_shadow;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // Properties.
  property p_reset_idle;
    $fell(rst_i) |-> int_n_o && pending_source_code_o == CODE_NONE && op_mode_o == MODE_CODE_NORMAL;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_code_int;
    // The code output trails the pin by one register, so it is held against the pin's previous value.
    pending_source_code_o != CODE_NONE |-> !$past(int_n_o);
  endproperty
  a_code_int: assert property (p_code_int) else $error("code pending but pin high");
  property p_tx;
    tx_empty_i[0] && en_shadow[BIT_TX0] |=> !int_n_o ##1 pending_source_code_o inside {[CODE_ERR:CODE_TX0]};
  endproperty
  a_tx: assert property (p_tx) else $error("tx empty did not interrupt");
  property p_mf;
    msg_fault_i && en_shadow[BIT_MSG_FAULT] |=> !int_n_o;
  endproperty
  a_mf: assert property (p_mf) else $error("message fault did not interrupt");
  property p_ovf;
    rx_overflow_i[0] && en_shadow[BIT_ERR] |=> !int_n_o ##1 pending_source_code_o == CODE_ERR;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow did not interrupt");
  property p_cnt;
    en_shadow[BIT_ERR] && tx_error_count_i >= WARN_LIMIT && $past(tx_error_count_i) < WARN_LIMIT
      |-> ##[1:3] !int_n_o;
  endproperty
  a_cnt: assert property (p_cnt) else $error("warning crossing did not interrupt");
  property p_wake;
    bus_activity_i && op_mode_o == MODE_CODE_SLEEP |-> ##[1:2] op_mode_o == MODE_CODE_LISTEN;
  endproperty
  a_wake: assert property (p_wake) else $error("no listen mode after wake");
  property p_nomask;
    en_shadow == 8'h00 && $past(en_shadow) == 8'h00 |-> int_n_o && pending_source_code_o == CODE_NONE;
  endproperty
  a_nomask: assert property (p_nomask) else $error("disabled source interrupted");
endmodule
bind ccil_int_logic ccil_checker #(.TX_CNT_W(TX_CNT_W)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_mod_i(reg_mod_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_mask_i(reg_mask_i),
  .tx_empty_i(tx_empty_i), .msg_fault_i(msg_fault_i), .bus_activity_i(bus_activity_i),
  .rx_overflow_i(rx_overflow_i), .tx_error_count_i(tx_error_count_i), .int_n_o(int_n_o),
  .pending_source_code_o(pending_source_code_o), .op_mode_o(op_mode_o)
);
`default_nettype wire

// file: verification/ccil_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccil_host_model
  import ccil_pkg::*;
(
  // Clock.
  input wire logic ref_clk_i,
  // Register access.
  output logic reg_wr_o,
  output logic reg_mod_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic [7:0] reg_mask_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_mod_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_mask_o = 8'h00;
  end
  // ====================
  // Kind 1 write, 2 masked update, 3 read. An idle cycle follows, so results have settled on return.
  task automatic acc(input logic [1:0] kind, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge ref_clk_i);
    reg_wr_o = (kind == 2'h1);
    reg_mod_o = (kind == 2'h2);
    reg_rd_o = (kind == 2'h3);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_mask_o = m;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    reg_mod_o = 1'b0;
    reg_rd_o = 1'b0;
    @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    acc(2'h3, a, 8'h00, 8'h00);
    d = reg_rdata_i;
  endtask
  // Clearing only through the mask, so a flag set meanwhile is never lost.
  task automatic clr(input logic [7:0] a, input logic [7:0] m);
    acc(2'h2, a, 8'h00, m);
  endtask
endmodule
`default_nettype wire

// file: verification/can_controller_interrupt_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module can_controller_interrupt_logic_tb_top;
  import ccil_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr;
  logic mod;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] mask;
  logic [7:0] rdata;
  logic [8:0] ev = 9'h000;
  logic [8:0] tx_error_count = 9'h000;
  logic [7:0] rec = 8'h00;
  logic mvld = 1'b0;
  logic [1:0] mreq = 2'h0;
  logic int_n;
  logic [2:0] code;
  logic [2:0] mode;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  ccil_host_model u_host (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_mod_o(mod), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_mask_o(mask), .reg_rdata_i(rdata));
  ccil_int_logic DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_mod_i(mod), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_mask_i(mask), .reg_rdata_o(rdata),
    .tx_empty_i(ev[2:0]), .rx_loaded_i(ev[4:3]), .msg_fault_i(ev[5]), .bus_activity_i(ev[6]),
    .rx_overflow_i(ev[8:7]), .tx_error_count_i(tx_error_count), .rx_error_count_i(rec), .mode_req_valid_i(mvld),
    .mode_req_i(mreq), .int_n_o(int_n), .pending_source_code_o(code), .op_mode_o(mode));
  // ====================
  // Common tasks.
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  // Event bits: tx 2:0, rx 4:3, fault 5, bus activity 6, overflow 8:7.
  task automatic pulse(input logic [8:0] v);
    @(negedge ref_clk_i);
    ev = v;
    @(negedge ref_clk_i);
    ev = 9'h000;
    // The source code output lands one edge after the flag, so let it settle.
    @(negedge ref_clk_i);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.rd(a, v);
    `CHK(n, e, v)
  endtask
  // ====================
  // Scenarios.
  task automatic t_regs();
    rdchk("enable", ADDR_INT_ENABLE, RESET_INT_ENABLE);
    rdchk("flags", ADDR_INT_FLAG, RESET_INT_FLAG);
    u_host.acc(2'h1, ADDR_INT_ENABLE, 8'ha5, 8'h00);
    rdchk("enable", ADDR_INT_ENABLE, 8'ha5);
    u_host.acc(2'h1, 8'h00, 8'h5a, 8'h00);
    rdchk("unmapped", 8'h00, 8'h00);
    `CHK("int", 1'b1, int_n)
  endtask
  task automatic t_mask();
    u_host.acc(2'h1, ADDR_INT_ENABLE, 8'h00, 8'h00);
    u_host.acc(2'h1, ADDR_INT_FLAG, 8'h04, 8'h00);
    `CHK("int", 1'b1, int_n)
    `CHK("code", CODE_NONE, code)
    u_host.acc(2'h1, ADDR_INT_ENABLE, 8'h04, 8'h00);
    `CHK("int", 1'b0, int_n)
    `CHK("code", CODE_TX0, code)
    u_host.clr(ADDR_INT_FLAG, 8'h04);
    `CHK("int", 1'b1, int_n)
  endtask
  task automatic t_prio();
    int ord[8] = '{5, 6, 2, 3, 4, 0, 1, 7};
    logic [2:0] want[8] = '{CODE_ERR, CODE_WAKE, CODE_TX0, CODE_TX1, CODE_TX2, CODE_RX0, CODE_RX1, CODE_NONE};
    logic [7:0] v;
    u_host.acc(2'h1, ADDR_INT_ENABLE, 8'hff, 8'h00);
    u_host.acc(2'h1, ADDR_INT_FLAG, 8'hff, 8'h00);
    for (int i = 0; i < 8; i++) begin
      `CHK("code", want[i], code)
      u_host.rd(ADDR_STATUS, v);
      `CHK("status", want[i], v[3:1])
      `CHK("int", 1'b0, int_n)
      u_host.clr(ADDR_INT_FLAG, 8'h01 << ord[i]);
    end
    `CHK("int", 1'b1, int_n)
  endtask
  task automatic t_events();
    for (int i = 0; i < 3; i++) begin
      pulse(9'h001 << i);
      `CHK("tx code", 3'(CODE_TX0 + i), code)
      u_host.clr(ADDR_INT_FLAG, 8'h04 << i);
      `CHK("tx int", 1'b1, int_n)
    end
    for (int i = 0; i < 2; i++) begin
      pulse(9'h008 << i);
      `CHK("rx code", 3'(CODE_RX0 + i), code)
      u_host.clr(ADDR_INT_FLAG, 8'h01 << i);
      `CHK("rx int", 1'b1, int_n)
    end
    pulse(9'h020);
    `CHK("fault int", 1'b0, int_n)
    rdchk("fault flag", ADDR_INT_FLAG, 8'h80);
    u_host.clr(ADDR_INT_FLAG, 8'h80);
  endtask
  task automatic t_ovf();
    pulse(9'h080);
    rdchk("ovf", ADDR_ERR_COND, 8'h40);
    `CHK("ovf code", CODE_ERR, code)
    u_host.clr(ADDR_INT_FLAG, 8'h20);
    rdchk("held", ADDR_INT_FLAG, 8'h20);
    u_host.clr(ADDR_ERR_COND, 8'h40);
    u_host.clr(ADDR_INT_FLAG, 8'h20);
    rdchk("freed", ADDR_INT_FLAG, 8'h00);
    `CHK("int", 1'b1, int_n)
  endtask
  task automatic t_counts();
    int t[9] = '{95, 96, 127, 128, 255, 256, 0, 0, 0};
    int r[9] = '{0, 0, 0, 0, 0, 0, 0, 128, 0};
    logic [7:0] c[9] = '{8'h00, 8'h05, 8'h05, 8'h15, 8'h15, 8'h35, 8'h00, 8'h0b, 8'h00};
    logic f[9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 9; i++) begin
      @(negedge ref_clk_i);
      tx_error_count = 9'(t[i]);
      rec = 8'(r[i]);
      rdchk("cond", ADDR_ERR_COND, c[i]);
      rdchk("err flag", ADDR_INT_FLAG, {2'h0, f[i], 5'h00});
      u_host.clr(ADDR_INT_FLAG, 8'h20);
    end
  endtask
  task automatic t_wake();
    @(negedge ref_clk_i);
    mreq = REQ_SLEEP;
    mvld = 1'b1;
    @(negedge ref_clk_i);
    mvld = 1'b0;
    @(negedge ref_clk_i);
    `CHK("sleep", MODE_CODE_SLEEP, mode)
    pulse(9'h040);
    @(negedge ref_clk_i);
    `CHK("listen", MODE_CODE_LISTEN, mode)
    `CHK("wake code", CODE_WAKE, code)
    rdchk("wake flag", ADDR_INT_FLAG, 8'h40);
    u_host.clr(ADDR_INT_FLAG, 8'h40);
    pulse(9'h040);
    rdchk("no wake", ADDR_INT_FLAG, 8'h00);
    @(negedge ref_clk_i);
    mreq = REQ_NORMAL;
    mvld = 1'b1;
    @(negedge ref_clk_i);
    mvld = 1'b0;
    @(negedge ref_clk_i);
    `CHK("normal", MODE_CODE_NORMAL, mode)
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_regs();
    t_mask();
    t_prio();
    t_events();
    t_ovf();
    t_counts();
    t_wake();
    finish_test();
  end
endmodule
`default_nettype wire
